// file: design/aet_act_ctrl.sv
`timescale 1ns/1ps
// Activation state sequencer: load and step requests, applied at baud ticks
module aet_act_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_reset,
  // Commands
  input wire logic baud_tick,
  input wire aet_pkg::aet_act_cmd_type cmd,
  input wire logic cont_ok,
  input wire logic [6:0] next_state,
  // State
  output logic [6:0] state,
  output logic step_done
);

  logic load_pend_reg;
  logic step_pend_reg;
  logic load_d_reg;
  logic step_d_reg;
  logic [6:0] state_reg;

  // ==========================================================
  // Edge capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_d_reg <= 1'b0;
      step_d_reg <= 1'b0;
    end else begin
      load_d_reg <= cmd.load_req;
      step_d_reg <= cmd.step_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_pend_reg <= 1'b0;
    end else if (soft_reset) begin
      load_pend_reg <= 1'b0;
    end else if (cmd.load_req && !load_d_reg) begin
      load_pend_reg <= 1'b1;
    end else if (baud_tick) begin
      load_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_pend_reg <= 1'b0;
    end else if (soft_reset) begin
      step_pend_reg <= 1'b0;
    end else if (cmd.step_req && !step_d_reg) begin
      step_pend_reg <= 1'b1;
    end else if (baud_tick && cont_ok && !load_pend_reg) begin
      step_pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // State update, once per baud
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= aet_pkg::STATE_RESET;
      step_done <= 1'b0;
    end else if (soft_reset) begin
      state_reg <= aet_pkg::STATE_RESET;
      step_done <= 1'b0;
    end else begin
      step_done <= 1'b0;
      if (baud_tick) begin
        if (load_pend_reg) begin
          state_reg <= cmd.state_value;
        end else if (step_pend_reg && cont_ok) begin
          state_reg <= next_state;
          step_done <= 1'b1;
        end else if (!cmd.hold && cont_ok) begin
          state_reg <= next_state;
        end
      end
    end
  end

  assign state = state_reg;

endmodule : aet_act_ctrl

// file: design/aet_test_regs.sv
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// How it works
// - read metric bits 18:11, write controls
// - readback bit returns written control values
// - hardware or software reset clears controls
// - DCH select reroutes activation test address
// - dump select reroutes echo test address
// - steer zero means autonomous CPU activation
// - interpolator follows bit in LT steer
// - rising load applies state within baud
// - load works despite hold
// - step advances once, overrides hold
// - hold freezes state until load/step
// - big jump selects four-unit phase steps
// - force linkup shows full duplex status
// - metric per frame, bits 10:3 readable
// - echo controls inert unless steer set
// - update bits freeze filter coefficients
// - accumulate bits shape symbol recovery
// - fast bits select highest adapt rate
// - clear zeros coefficients, resets buffer
module aet_test_regs (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU side
  input wire logic frame_tick,
  input wire logic [18:0] metric_in,
  input wire logic cont_ok,
  input wire logic [6:0] next_state,
  // Overlay ports
  input wire logic [7:0] dch_rdata,
  output logic dch_wr,
  output logic dch_rd,
  input wire logic [7:0] dump_rdata,
  output logic dump_wr,
  output logic dump_rd,
  output logic [7:0] port_wdata,
  // Steering outputs
  output logic steer,
  output aet_pkg::aet_ctrl_type ctrl,
  output logic [6:0] act_state,
  output logic act_step_done,
  output logic full_duplex_status,
  output logic [2:0] phase_jump_size
);

  logic [7:0] act_test_reg;
  logic [7:0] ec_test_reg;
  logic [7:0] act_state_reg;
  logic [2:0] overlay_reg;
  logic [7:0] diag_reg;
  logic [2:0] core_cfg_reg;
  logic [18:0] metric_reg;
  logic [8:0] baud_cnt_reg;
  logic baud_tick;
  logic soft_reset;
  logic wr_en;
  logic rd_en;
  logic dch_hit;
  logic dump_hit;
  logic [31:0] rdata_next;
  logic err_next;
  aet_pkg::aet_act_cmd_type cmd;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // ==========================================================
  // Bus decode; zero wait state
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign soft_reset = wr_en && hit(paddr, aet_pkg::NIBBLE_CTRL_OFFSET)
    && pwdata[aet_pkg::SW_RESET_BIT];
  assign dch_hit = overlay_reg[aet_pkg::DCH_SEL_BIT] && hit(paddr, aet_pkg::ACT_TEST_OFFSET);
  assign dump_hit = overlay_reg[aet_pkg::DUMP_SEL_BIT] && hit(paddr, aet_pkg::EC_TEST_OFFSET);
  assign dch_wr = wr_en && dch_hit;
  assign dch_rd = rd_en && dch_hit;
  assign dump_wr = wr_en && dump_hit;
  assign dump_rd = rd_en && dump_hit;
  assign port_wdata = pwdata[7:0];

  // ==========================================================
  // Test registers
  // clear on both resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_test_reg <= aet_pkg::TEST_RESET;
      ec_test_reg <= aet_pkg::TEST_RESET;
      act_state_reg <= aet_pkg::TEST_RESET;
      diag_reg <= aet_pkg::TEST_RESET;
    end else if (soft_reset) begin
      act_test_reg <= aet_pkg::TEST_RESET;
      ec_test_reg <= aet_pkg::TEST_RESET;
      act_state_reg <= aet_pkg::TEST_RESET;
      diag_reg <= aet_pkg::TEST_RESET;
    end else if (wr_en) begin
      if (hit(paddr, aet_pkg::ACT_TEST_OFFSET) && !dch_hit) begin
        act_test_reg <= pwdata[7:0];
      end
      if (hit(paddr, aet_pkg::EC_TEST_OFFSET) && !dump_hit) begin
        ec_test_reg <= pwdata[7:0];
      end
      if (hit(paddr, aet_pkg::ACT_STATE_OFFSET)) begin
        act_state_reg <= pwdata[7:0];
      end
      if (hit(paddr, aet_pkg::DIAG_OFFSET)) begin
        diag_reg <= pwdata[7:0];
      end
    end
  end

  // Overlay select is cleared by hardware reset only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overlay_reg <= 3'h0;
      core_cfg_reg <= 3'h0;
    end else if (wr_en) begin
      if (hit(paddr, aet_pkg::OVERLAY_OFFSET)) begin
        overlay_reg <= pwdata[2:0];
      end
      if (hit(paddr, aet_pkg::CORE_CFG_OFFSET)) begin
        core_cfg_reg <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      metric_reg <= 19'h00000;
    end else if (frame_tick) begin
      metric_reg <= metric_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_reg <= 9'h000;
    end else if (baud_cnt_reg == 9'(aet_pkg::BAUD_CYCLES - 1)) begin
      baud_cnt_reg <= 9'h000;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 9'h001;
    end
  end
  assign baud_tick = (baud_cnt_reg == 9'(aet_pkg::BAUD_CYCLES - 1));

  // ==========================================================
  // Read mux, combinational
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    if (dch_hit) begin
      rdata_next = {24'h000000, dch_rdata};
    end else if (dump_hit) begin
      rdata_next = {24'h000000, dump_rdata};
    end else if (hit(paddr, aet_pkg::ACT_TEST_OFFSET)) begin
      if (diag_reg[aet_pkg::READBACK_BIT]) begin
        rdata_next = {24'h000000, act_test_reg};
      end else begin
        rdata_next = {24'h000000, metric_reg[18:11]};
      end
    end else if (hit(paddr, aet_pkg::EC_TEST_OFFSET)) begin
      if (diag_reg[aet_pkg::READBACK_BIT]) begin
        rdata_next = {24'h000000, ec_test_reg};
      end else begin
        rdata_next = {24'h000000, metric_reg[10:3]};
      end
    end else if (hit(paddr, aet_pkg::ACT_STATE_OFFSET)) begin
      if (diag_reg[aet_pkg::READBACK_BIT]) begin
        rdata_next = {24'h000000, act_state_reg};
      end else begin
        rdata_next = {24'h000000, act_state, 1'b0};
      end
    end else if (hit(paddr, aet_pkg::OVERLAY_OFFSET)) begin
      rdata_next = {29'h00000000, overlay_reg};
    end else if (hit(paddr, aet_pkg::DIAG_OFFSET)) begin
      rdata_next = {24'h000000, diag_reg};
    end else if (hit(paddr, aet_pkg::CORE_CFG_OFFSET)) begin
      rdata_next = {29'h00000000, core_cfg_reg};
    end else if (!hit(paddr, aet_pkg::NIBBLE_CTRL_OFFSET)) begin
      rdata_next = aet_pkg::SLVERR_DATA;
      err_next = 1'b1;
    end
  end

  assign prdata = (psel && penable) ? rdata_next : 32'h0000_0000;
  assign pslverr = psel && penable && err_next;

  // ==========================================================
  // Steering
  // steer gates CPU override
  assign steer = act_test_reg[aet_pkg::STEER_BIT];
  assign ctrl.interp_en = steer ? (core_cfg_reg[aet_pkg::LT_MODE_BIT]
    && act_test_reg[aet_pkg::INTERP_BIT]) : core_cfg_reg[aet_pkg::LT_MODE_BIT];
  assign ctrl.big_jump = act_test_reg[aet_pkg::BIGJUMP_BIT];
  assign phase_jump_size = act_test_reg[aet_pkg::BIGJUMP_BIT] ? 3'h4 : 3'h1;
  assign ctrl.force_linkup = act_test_reg[aet_pkg::FORCE_LINK_BIT];
  assign full_duplex_status = act_test_reg[aet_pkg::FORCE_LINK_BIT];
  assign ctrl.freq_adapt = !steer || core_cfg_reg[aet_pkg::FREQ_ADAPT_BIT];
  assign ctrl.jump_disable = steer && core_cfg_reg[aet_pkg::JUMP_DIS_BIT];
  assign ctrl.mec_update = !steer || ec_test_reg[aet_pkg::MEC_UPD_BIT];
  assign ctrl.ec_update = !steer || ec_test_reg[aet_pkg::EC_UPD_BIT];
  assign ctrl.dfe_update = !steer || ec_test_reg[aet_pkg::DFE_UPD_BIT];
  assign ctrl.accumulate_ec = !steer || ec_test_reg[aet_pkg::ACC_EC_BIT];
  assign ctrl.accumulate_dfe = !steer || ec_test_reg[aet_pkg::ACC_DFE_BIT];
  assign ctrl.fast_ec = steer && ec_test_reg[aet_pkg::FAST_EC_BIT];
  assign ctrl.fast_dfe = steer && ec_test_reg[aet_pkg::FAST_DFE_BIT];
  assign ctrl.clear_coeff = steer && ec_test_reg[aet_pkg::CLEAR_BIT];

  // Load, step and hold only act while steering
  assign cmd.load_req = steer && act_test_reg[aet_pkg::LOAD_BIT];
  assign cmd.step_req = steer && act_test_reg[aet_pkg::STEP_BIT];
  assign cmd.hold = steer && act_test_reg[aet_pkg::HOLD_BIT];
  assign cmd.state_value = act_state_reg[7:1];

  aet_act_ctrl u_act (
    .pclk(pclk),
    .presetn(presetn),
    .soft_reset(soft_reset),
    .baud_tick(baud_tick),
    .cmd(cmd),
    .cont_ok(cont_ok),
    .next_state(next_state),
    .state(act_state),
    .step_done(act_step_done)
  );

endmodule : aet_test_regs

// file: inc/aet_pkg.sv
package aet_pkg;

  // ==========================================================
  // Register byte offsets (APB, one aligned word each)
  localparam logic [7:0] ACT_TEST_OFFSET = 8'h00;
  localparam logic [7:0] EC_TEST_OFFSET = 8'h04;
  localparam logic [7:0] ACT_STATE_OFFSET = 8'h08;
  localparam logic [7:0] OVERLAY_OFFSET = 8'h0c;
  localparam logic [7:0] DIAG_OFFSET = 8'h10;
  localparam logic [7:0] NIBBLE_CTRL_OFFSET = 8'h14;
  localparam logic [7:0] CORE_CFG_OFFSET = 8'h18;

  // ==========================================================
  // Field positions
  localparam int STEER_BIT = 7;
  localparam int INTERP_BIT = 6;
  localparam int LOAD_BIT = 5;
  localparam int STEP_BIT = 4;
  localparam int HOLD_BIT = 3;
  localparam int BIGJUMP_BIT = 2;
  localparam int FORCE_LINK_BIT = 0;
  localparam int MEC_UPD_BIT = 7;
  localparam int ACC_EC_BIT = 6;
  localparam int EC_UPD_BIT = 5;
  localparam int FAST_EC_BIT = 4;
  localparam int ACC_DFE_BIT = 3;
  localparam int DFE_UPD_BIT = 2;
  localparam int FAST_DFE_BIT = 1;
  localparam int CLEAR_BIT = 0;
  localparam int READBACK_BIT = 6;
  localparam int SW_RESET_BIT = 3;
  localparam int DCH_SEL_BIT = 1;
  localparam int DUMP_SEL_BIT = 2;
  localparam int FREQ_ADAPT_BIT = 1;
  localparam int JUMP_DIS_BIT = 0;
  localparam int LT_MODE_BIT = 2;

  // ==========================================================
  // Reset values and widths
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [6:0] STATE_RESET = 7'h00;
  localparam int METRIC_W = 19;
  localparam logic [31:0] SLVERR_DATA = 32'h0000_0000;

  // ==========================================================
  // Timing: one baud at 80 kbaud against 25 MHz
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_HZ = 80_000;
  localparam int BAUD_CYCLES = CLK_HZ / BAUD_HZ;

  typedef struct packed {
    logic interp_en;
    logic big_jump;
    logic force_linkup;
    logic freq_adapt;
    logic jump_disable;
    logic mec_update;
    logic ec_update;
    logic accumulate_ec;
    logic fast_ec;
    logic accumulate_dfe;
    logic dfe_update;
    logic fast_dfe;
    logic clear_coeff;
  } aet_ctrl_type;

  typedef struct packed {
    logic load_req;
    logic step_req;
    logic hold;
    logic [6:0] state_value;
  } aet_act_cmd_type;

endpackage : aet_pkg

// file: tb/aet_cpu_model.sv
`timescale 1ns/1ps
// ==========================================================
// Internal CPU stand-in: frame ticks, metric, next state, overlay data
module aet_cpu_model #(
  parameter int FRAME = 60,
  parameter logic [18:0] METRIC = 19'h5b2e7,
  parameter logic [7:0] DCH_BYTE = 8'h3a,
  parameter logic [7:0] DUMP_BYTE = 8'hc6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller view
  input wire logic [6:0] act_state,
  output logic frame_tick,
  output logic [18:0] metric_in,
  output logic cont_ok,
  output logic [6:0] next_state,
  // Overlay port data
  output logic [7:0] dch_rdata,
  output logic [7:0] dump_rdata
);
  logic [7:0] frame_cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt_reg <= 8'h00;
    end else begin
      frame_cnt_reg <= (frame_cnt_reg == 8'(FRAME - 1)) ? 8'h00 : frame_cnt_reg + 8'h01;
    end
  end

  // Metric held steady so reads after the first frame tick have one expected value
  assign frame_tick = (frame_cnt_reg == 8'(FRAME - 1));
  assign metric_in = METRIC;
  assign cont_ok = 1'b1;
  assign next_state = act_state + 7'h01;
  assign dch_rdata = DCH_BYTE;
  assign dump_rdata = DUMP_BYTE;
endmodule : aet_cpu_model

// file: tb/aet_test_regs_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level checks of the test register bank
module aet_test_regs_checker (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  // Outputs watched
  input wire logic dch_wr,
  input wire logic dump_rd,
  input wire logic steer,
  input wire aet_pkg::aet_ctrl_type ctrl,
  input wire logic [6:0] act_state,
  input wire logic act_step_done,
  input wire logic full_duplex_status,
  input wire logic [2:0] phase_jump_size
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_reset;
    $rose(presetn) |-> act_state == 7'h00 && !steer;
  endproperty
  a_reset: assert property (p_reset) else $error("state not clear after reset");
  property p_read_gate;
    !(psel && penable) |-> prdata == 32'h0000_0000;
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("read data outside access");
  property p_dch_wr;
    dch_wr |-> psel && penable && pwrite && paddr == aet_pkg::ACT_TEST_OFFSET;
  endproperty
  a_dch_wr: assert property (p_dch_wr) else $error("stray port write strobe");
  property p_dump_rd;
    dump_rd |-> psel && penable && !pwrite && paddr == aet_pkg::EC_TEST_OFFSET;
  endproperty
  a_dump_rd: assert property (p_dump_rd) else $error("stray dump read strobe");
  property p_jump;
    phase_jump_size == (ctrl.big_jump ? 3'h4 : 3'h1);
  endproperty
  a_jump: assert property (p_jump) else $error("phase jump size wrong");
  property p_fdx;
    ctrl.force_linkup |-> full_duplex_status;
  endproperty
  a_fdx: assert property (p_fdx) else $error("full duplex not forced");
  property p_steer_off;
    !steer |-> ctrl.mec_update && ctrl.ec_update && ctrl.dfe_update && ctrl.accumulate_ec
      && ctrl.accumulate_dfe && !ctrl.fast_ec && !ctrl.fast_dfe && !ctrl.clear_coeff;
  endproperty
  a_steer_off: assert property (p_steer_off) else $error("echo controls active");
  property p_step_pulse;
    act_step_done |=> !act_step_done ##1 $stable(act_state);
  endproperty
  a_step_pulse: assert property (p_step_pulse) else $error("step not single");
endmodule : aet_test_regs_checker

bind aet_test_regs aet_test_regs_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .dch_wr(dch_wr),
  .dump_rd(dump_rd), .steer(steer), .ctrl(ctrl), .act_state(act_state),
  .act_step_done(act_step_done), .full_duplex_status(full_duplex_status),
  .phase_jump_size(phase_jump_size));

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, frame_tick, cont_ok, dch_wr, dch_rd, dump_wr, dump_rd, steer;
  logic act_step_done, full_duplex_status;
  logic [18:0] metric_in;
  logic [6:0] next_state, act_state;
  logic [7:0] dch_rdata, dump_rdata, port_wdata;
  logic [2:0] phase_jump_size;
  aet_pkg::aet_ctrl_type ctrl, e;
  int errors = 0;
  int checked = 0;
  localparam logic [18:0] METRIC = 19'h5b2e7;

  always #20 pclk = ~pclk;

  aet_test_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .frame_tick, .metric_in, .cont_ok, .next_state, .dch_rdata, .dch_wr,
    .dch_rd, .dump_rdata, .dump_wr, .dump_rd, .port_wdata, .steer, .ctrl, .act_state,
    .act_step_done, .full_duplex_status, .phase_jump_size);
  aet_cpu_model #(.METRIC(METRIC)) cpu_u (.pclk, .presetn, .act_state, .frame_tick,
    .metric_in, .cont_ok, .next_state, .dch_rdata, .dump_rdata);

  // ==========================================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic err;
    apb(1'b1, a, {24'h0, d}, q, err);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    logic err;
    apb(1'b0, a, 32'h0, q, err);
    chk(q, {24'h0, exp});
  endtask : rd_chk

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] q;
    logic err;
    chk(32'(act_state), 32'h0);
    wr(aet_pkg::DIAG_OFFSET, 8'h40);
    rd_chk(aet_pkg::ACT_TEST_OFFSET, 8'h00);
    rd_chk(aet_pkg::EC_TEST_OFFSET, 8'h00);
    wr(aet_pkg::DIAG_OFFSET, 8'h00);
    apb(1'b0, 8'h40, 32'h0, q, err);
    chk(32'(err), 32'h1);
    repeat (70) @(posedge pclk);
    rd_chk(aet_pkg::ACT_TEST_OFFSET, METRIC[18:11]);
    rd_chk(aet_pkg::EC_TEST_OFFSET, METRIC[10:3]);
  endtask : t_reset

  task automatic t_steer;
    wr(aet_pkg::CORE_CFG_OFFSET, 8'h04);
    wr(aet_pkg::EC_TEST_OFFSET, 8'h00);
    e = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    chk(32'(ctrl), 32'(e));
    wr(aet_pkg::CORE_CFG_OFFSET, 8'h05);
    wr(aet_pkg::EC_TEST_OFFSET, 8'ha5);
    wr(aet_pkg::ACT_TEST_OFFSET, 8'hc5);
    e = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    chk(32'(ctrl), 32'(e));
    chk(32'(phase_jump_size), 32'h4);
    chk(32'(full_duplex_status), 32'h1);
    wr(aet_pkg::DIAG_OFFSET, 8'h40);
    rd_chk(aet_pkg::ACT_TEST_OFFSET, 8'hc5);
    rd_chk(aet_pkg::EC_TEST_OFFSET, 8'ha5);
    wr(aet_pkg::DIAG_OFFSET, 8'h00);
    wr(aet_pkg::ACT_TEST_OFFSET, 8'h80);
    chk(32'(ctrl.interp_en), 32'h0);
    chk(32'(phase_jump_size), 32'h1);
  endtask : t_steer

  task automatic t_load_step;
    int n;
    wr(aet_pkg::ACT_TEST_OFFSET, 8'h88);
    wr(aet_pkg::ACT_STATE_OFFSET, {7'h2a, 1'b0});
    wr(aet_pkg::ACT_TEST_OFFSET, 8'ha8);
    n = 0;
    while (act_state !== 7'h2a && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(act_state), 32'h2a);
    chk(32'(n <= aet_pkg::BAUD_CYCLES + 4), 32'h1);
    wr(aet_pkg::ACT_TEST_OFFSET, 8'h88);
    repeat (700) @(posedge pclk);
    chk(32'(act_state), 32'h2a);
    wr(aet_pkg::ACT_TEST_OFFSET, 8'h98);
    n = 0;
    while (act_state !== 7'h2b && n < 400) begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    chk(32'(act_state), 32'h2b);
    wr(aet_pkg::ACT_TEST_OFFSET, 8'h88);
    repeat (700) @(posedge pclk);
    chk(32'(act_state), 32'h2b);
  endtask : t_load_step

  task automatic t_overlay;
    wr(aet_pkg::OVERLAY_OFFSET, 8'h06);
    wr(aet_pkg::ACT_TEST_OFFSET, 8'h00);
    chk(32'(steer), 32'h1);
    rd_chk(aet_pkg::ACT_TEST_OFFSET, 8'h3a);
    rd_chk(aet_pkg::EC_TEST_OFFSET, 8'hc6);
    wr(aet_pkg::OVERLAY_OFFSET, 8'h00);
    wr(aet_pkg::NIBBLE_CTRL_OFFSET, 8'h08);
    chk(32'(steer), 32'h0);
    chk(32'(act_state), 32'h0);
  endtask : t_overlay

  // ==========================================================
  // Run control
  task automatic stop_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_steer();
    t_load_step();
    t_overlay();
    stop_test();
  end

  // Whole run needs about 2000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    stop_test();
  end
endmodule : testbench
